//--- src/cls_supervisor.sv
// How it works
// - Profile code 0..13, 0 inactive, selects network
// - Codes 11..13 are Ethernet, 2/4/6 words
// - Format 1..9: Modbus-RTU, baud groups, parity cycles
// - Format accepts 0..9, resets to 7
// - Separate alarms: serial, fieldbus link, card, boards
// - Loss action code picks stop, enable, local, fault
// - Serial silence past timeout raises alarm, acts
// - Zero timeout disables watchdog, default zero
// - Serial action only with serial command source
// - Profile, format, timeout change only motor stopped
// - Relay link selector 0..2, default panel
// - Relay silence disables drive output
// - Station address 1..30, default 1
`timescale 1ns/1ps
`default_nettype none
module cls_supervisor #(
  parameter int unsigned TICK_CYCLES = cls_pkg::TENTH_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Setting writes, each with its own strobe
  input wire logic wr_profile,
  input wire logic wr_format,
  input wire logic wr_timeout,
  input wire logic wr_action,
  input wire logic wr_relay_sel,
  input wire logic wr_address,
  input wire logic [3:0] wr_data_code,
  input wire logic [13:0] wr_data_timeout,
  input wire logic [4:0] wr_data_address,
  // Drive state
  input wire logic motor_running,
  input wire logic cmd_source_serial,
  input wire logic comm_fault_reset,
  // Serial receiver and relay poller, same clock
  input wire logic telegram_valid,
  input wire logic [4:0] telegram_address,
  input wire logic relay_reply_valid,
  // Pins, asynchronous
  input wire logic fieldbus_link_ok,
  input wire logic fieldbus_card_active,
  input wire logic board_link_ok,
  // Settings readback
  output logic [3:0] fieldbus_profile_select,
  output logic [3:0] serial_format_select,
  output logic [13:0] serial_timeout,
  output logic [2:0] comm_loss_action,
  output logic [1:0] thermal_relay_link_select,
  output logic [4:0] serial_station_address,
  output logic cfg_reject,
  // Decoded configuration
  output cls_pkg::cls_net_e net_type,
  output logic [2:0] io_words,
  output logic serial_enable,
  output logic [1:0] serial_baud_sel,
  output logic [1:0] serial_parity_sel,
  // Alarms and actions
  output logic serial_silence_alarm,
  output logic fieldbus_link_alarm,
  output logic fieldbus_card_alarm,
  output logic board_link_alarm,
  output logic relay_timeout_alarm,
  output logic run_stop_disable,
  output logic gen_enable_drop,
  output logic go_local,
  output logic comm_fault,
  output logic output_disable
);
  import cls_pkg::*;

  function automatic cls_net_e net_of(input logic [3:0] code);
    if (code == PROFILE_INACTIVE || code > PROFILE_MAX) return CLS_NET_NONE;
    if (code == PROFILE_DRIVE) return CLS_NET_DRIVE_PROFILE;
    if (code >= PROFILE_ETH_FIRST) return CLS_NET_ETHERNET;
    case ((code - 4'h1) / IO_GROUP)
      4'h0: return CLS_NET_PROFIBUS;
      4'h1: return CLS_NET_DEVICENET;
      default: return CLS_NET_MODBUS;
    endcase
  endfunction

  // Position within a group of three: selects 2, 4 or 6 words or parity
  function automatic logic [1:0] slot_of(input logic [3:0] code);
    if (code >= PROFILE_ETH_FIRST) return 2'(code - PROFILE_ETH_FIRST);
    return 2'((code - 4'h1) % IO_GROUP);
  endfunction

  // Synchronisers for the three pins
  logic [2:0] pin_s1_r, pin_s2_r;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          pin_s1_r[gi] <= 1'b1;
          pin_s2_r[gi] <= 1'b1;
        end else begin
          pin_s1_r[gi] <= (gi == 0) ? fieldbus_link_ok :
                          (gi == 1) ? fieldbus_card_active : board_link_ok;
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  // Settings
  logic [3:0] profile_r, profile_nxt, format_r, format_nxt;
  logic [13:0] timeout_r, timeout_nxt;
  logic [2:0] action_r, action_nxt;
  logic [1:0] relay_sel_r, relay_sel_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic reject_r, reject_nxt;

  always_comb begin
    profile_nxt = profile_r;
    format_nxt = format_r;
    timeout_nxt = timeout_r;
    action_nxt = action_r;
    relay_sel_nxt = relay_sel_r;
    addr_nxt = addr_r;
    reject_nxt = 1'b0;
    if (wr_profile) begin
      if (!motor_running && wr_data_code <= PROFILE_MAX)
        profile_nxt = wr_data_code;
      else
        reject_nxt = 1'b1;
    end
    if (wr_format) begin
      if (!motor_running && wr_data_code <= FORMAT_MAX)
        format_nxt = wr_data_code;
      else
        reject_nxt = 1'b1;
    end
    if (wr_timeout) begin
      if (!motor_running && wr_data_timeout <= TIMEOUT_MAX)
        timeout_nxt = wr_data_timeout;
      else
        reject_nxt = 1'b1;
    end
    if (wr_action) begin
      // Reserved code is refused so no undefined reaction can be armed
      if (wr_data_code <= 4'(ACT_FAULT) && wr_data_code != 4'(ACT_RESERVED))
        action_nxt = 3'(wr_data_code);
      else
        reject_nxt = 1'b1;
    end
    if (wr_relay_sel) begin
      if (wr_data_code <= 4'(RELAY_SEL_MAX))
        relay_sel_nxt = 2'(wr_data_code);
      else
        reject_nxt = 1'b1;
    end
    if (wr_address) begin
      if (wr_data_address >= ADDR_MIN && wr_data_address <= ADDR_MAX)
        addr_nxt = wr_data_address;
      else
        reject_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      profile_r <= PROFILE_RESET;
      format_r <= FORMAT_RESET;
      timeout_r <= TIMEOUT_RESET;
      action_r <= ACT_RESET;
      relay_sel_r <= RELAY_SEL_RESET;
      addr_r <= ADDR_RESET;
      reject_r <= 1'b0;
    end else begin
      profile_r <= profile_nxt;
      format_r <= format_nxt;
      timeout_r <= timeout_nxt;
      action_r <= action_nxt;
      relay_sel_r <= relay_sel_nxt;
      addr_r <= addr_nxt;
      reject_r <= reject_nxt;
    end
  end

  // Watchdog timers
  cls_timer_if serial_tif ();
  cls_timer_if relay_tif ();
  logic addressed;

  // Broadcast telegrams also prove the master is alive
  assign addressed = telegram_valid &&
    (telegram_address == addr_r || telegram_address == ADDR_BROADCAST);
  assign serial_tif.restart = addressed || wr_timeout;
  assign serial_tif.limit = timeout_r;
  // Relay polling by the relay link itself; 2400 even framing is its own
  assign relay_tif.restart = relay_reply_valid;
  assign relay_tif.limit = (relay_sel_r == RELAY_SEL_PANEL) ? 14'h0000 :
                           RELAY_TIMEOUT_TENTHS;

  cls_timer #(.TICK_CYCLES(TICK_CYCLES)) u_serial_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .tif(serial_tif)
  );

  cls_timer #(.TICK_CYCLES(TICK_CYCLES)) u_relay_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .tif(relay_tif)
  );

  // Alarms, decode and actions
  cls_net_e net_r, net_nxt;
  logic [2:0] io_r, io_nxt;
  logic ser_en_r, ser_en_nxt;
  logic [1:0] baud_r, baud_nxt, parity_r, parity_nxt;
  logic [4:0] alarm_r, alarm_nxt;
  logic [2:0] act_r, act_nxt;
  logic fault_r, fault_nxt, odis_r, odis_nxt, loss;

  always_comb begin
    net_nxt = net_of(profile_r);
    io_nxt = '0;
    if (net_nxt != CLS_NET_NONE && net_nxt != CLS_NET_DRIVE_PROFILE)
      io_nxt = 3'({slot_of(profile_r), 1'b0} + 3'h2);
    ser_en_nxt = format_r != FORMAT_UNUSED;
    baud_nxt = ser_en_nxt ? 2'((format_r - 4'h1) / IO_GROUP) : 2'h0;
    parity_nxt = ser_en_nxt ? slot_of(format_r) : 2'h0;
    alarm_nxt[0] = serial_tif.expired;
    alarm_nxt[1] = profile_r != PROFILE_INACTIVE && !pin_s2_r[0];
    alarm_nxt[2] = profile_r != PROFILE_INACTIVE && !pin_s2_r[1];
    alarm_nxt[3] = !pin_s2_r[2];
    alarm_nxt[4] = relay_tif.expired;
    loss = (alarm_r[0] && cmd_source_serial) || (|alarm_r[3:1]);
    act_nxt[0] = loss && action_r == ACT_RUN_STOP;
    act_nxt[1] = loss && action_r == ACT_GEN_ENABLE;
    act_nxt[2] = loss && action_r == ACT_LOCAL;
    // A latched fault survives the link coming back; a new loss beats reset
    fault_nxt = fault_r && !comm_fault_reset;
    if (loss && action_r == ACT_FAULT)
      fault_nxt = 1'b1;
    odis_nxt = alarm_r[4];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      net_r <= CLS_NET_NONE;
      io_r <= '0;
      ser_en_r <= 1'b0;
      baud_r <= '0;
      parity_r <= '0;
      alarm_r <= '0;
      act_r <= '0;
      fault_r <= 1'b0;
      odis_r <= 1'b0;
    end else begin
      net_r <= net_nxt;
      io_r <= io_nxt;
      ser_en_r <= ser_en_nxt;
      baud_r <= baud_nxt;
      parity_r <= parity_nxt;
      alarm_r <= alarm_nxt;
      act_r <= act_nxt;
      fault_r <= fault_nxt;
      odis_r <= odis_nxt;
    end
  end

  assign fieldbus_profile_select = profile_r;
  assign serial_format_select = format_r;
  assign serial_timeout = timeout_r;
  assign comm_loss_action = action_r;
  assign thermal_relay_link_select = relay_sel_r;
  assign serial_station_address = addr_r;
  assign cfg_reject = reject_r;
  assign net_type = net_r;
  assign io_words = io_r;
  assign serial_enable = ser_en_r;
  assign serial_baud_sel = baud_r;
  assign serial_parity_sel = parity_r;
  assign serial_silence_alarm = alarm_r[0];
  assign fieldbus_link_alarm = alarm_r[1];
  assign fieldbus_card_alarm = alarm_r[2];
  assign board_link_alarm = alarm_r[3];
  assign relay_timeout_alarm = alarm_r[4];
  assign run_stop_disable = act_r[0];
  assign gen_enable_drop = act_r[1];
  assign go_local = act_r[2];
  assign comm_fault = fault_r;
  assign output_disable = odis_r;

  chk_format_reset_val: assert property (@(posedge sys_clk)
    $past(srst) && !srst |-> format_r == FORMAT_RESET && timeout_r == '0)
    else $error("format or timeout wrong after reset");
  chk_profile_in_range: assert property (@(posedge sys_clk)
    disable iff (srst) profile_r <= PROFILE_MAX && format_r <= FORMAT_MAX)
    else $error("profile or format out of range");
  chk_running_no_change: assert property (@(posedge sys_clk)
    disable iff (srst) motor_running && (wr_profile || wr_format ||
    wr_timeout) |=> $stable(profile_r) && $stable(format_r) &&
    $stable(timeout_r) && cfg_reject)
    else $error("setting changed while motor running");
  chk_eth_words: assert property (@(posedge sys_clk)
    disable iff (srst) profile_r == PROFILE_ETH_FIRST && $stable(profile_r)
    |=> net_type == CLS_NET_ETHERNET && io_words == 3'h2)
    else $error("ethernet decode wrong");
  chk_zero_timeout_quiet: assert property (@(posedge sys_clk)
    disable iff (srst) timeout_r == '0 && $past(timeout_r) == '0 &&
    $past(timeout_r, 2) == '0 |-> !serial_silence_alarm)
    else $error("serial alarm with watchdog disabled");
  chk_telegram_clears: assert property (@(posedge sys_clk)
    disable iff (srst) addressed |-> ##2 !serial_silence_alarm)
    else $error("valid telegram did not clear alarm");
  chk_serial_source_gate: assert property (@(posedge sys_clk)
    disable iff (srst) serial_silence_alarm && !cmd_source_serial &&
    !(|alarm_r[3:1]) && action_r == ACT_RUN_STOP |=> !run_stop_disable)
    else $error("serial action without serial source");
  chk_silence_acts: assert property (@(posedge sys_clk)
    disable iff (srst) serial_silence_alarm && cmd_source_serial &&
    action_r == ACT_LOCAL |=> go_local)
    else $error("serial silence did not act");
  chk_fault_latched: assert property (@(posedge sys_clk)
    disable iff (srst) comm_fault && !comm_fault_reset |=> comm_fault)
    else $error("fault dropped without reset");
  chk_relay_disable: assert property (@(posedge sys_clk)
    disable iff (srst) relay_timeout_alarm |=> output_disable)
    else $error("relay silence did not disable output");
  chk_addr_range: assert property (@(posedge sys_clk)
    disable iff (srst) addr_r >= ADDR_MIN && addr_r <= ADDR_MAX)
    else $error("station address out of range");
  chk_card_alarm: assert property (@(posedge sys_clk)
    disable iff (srst) fieldbus_card_alarm |-> $past(profile_r) != '0)
    else $error("card alarm with fieldbus inactive");
endmodule
`default_nettype wire

//--- src/cls_pkg.sv
package cls_pkg;
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TENTH_SEC_NS = 100_000_000;
  localparam int unsigned TENTH_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned PRE_W = 24;

  // Fieldbus profile codes
  localparam logic [3:0] PROFILE_INACTIVE = 4'h0;
  localparam logic [3:0] PROFILE_MAX = 4'hD;
  localparam logic [3:0] PROFILE_MODBUS_LAST = 4'h9;
  localparam logic [3:0] PROFILE_DRIVE = 4'hA;
  localparam logic [3:0] PROFILE_ETH_FIRST = 4'hB;
  localparam logic [3:0] PROFILE_RESET = 4'h0;
  localparam logic [3:0] IO_GROUP = 4'h3;

  // Serial format codes
  localparam logic [3:0] FORMAT_UNUSED = 4'h0;
  localparam logic [3:0] FORMAT_MAX = 4'h9;
  localparam logic [3:0] FORMAT_RESET = 4'h7;

  // Loss action codes
  localparam logic [2:0] ACT_RUN_STOP = 3'h0;
  localparam logic [2:0] ACT_GEN_ENABLE = 3'h1;
  localparam logic [2:0] ACT_NONE = 3'h2;
  localparam logic [2:0] ACT_LOCAL = 3'h3;
  localparam logic [2:0] ACT_RESERVED = 3'h4;
  localparam logic [2:0] ACT_FAULT = 3'h5;
  localparam logic [2:0] ACT_RESET = 3'h0;

  // Serial timeout in tenths of a second
  localparam logic [13:0] TIMEOUT_MAX = 14'h2706;
  localparam logic [13:0] TIMEOUT_RESET = 14'h0000;

  // Thermal relay link
  localparam logic [1:0] RELAY_SEL_PANEL = 2'h0;
  localparam logic [1:0] RELAY_SEL_MAX = 2'h2;
  localparam logic [1:0] RELAY_SEL_RESET = 2'h0;
  localparam logic [13:0] RELAY_TIMEOUT_TENTHS = 14'h000A;

  // Station address
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam logic [4:0] ADDR_RESET = 5'h01;
  localparam logic [4:0] ADDR_BROADCAST = 5'h00;

  typedef enum logic [2:0] {
    CLS_NET_NONE,
    CLS_NET_PROFIBUS,
    CLS_NET_DEVICENET,
    CLS_NET_MODBUS,
    CLS_NET_DRIVE_PROFILE,
    CLS_NET_ETHERNET
  } cls_net_e;
endpackage

//--- src/cls_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cls_timer_if;
  logic restart;
  logic [13:0] limit;
  logic expired;
  modport owner (output restart, output limit, input expired);
  modport timer (input restart, input limit, output expired);
endinterface
`default_nettype wire

//--- src/cls_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cls_timer #(
  parameter int unsigned TICK_CYCLES = cls_pkg::TENTH_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  cls_timer_if.timer tif
);
  import cls_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [13:0] tenths_r, tenths_nxt;
  logic expired_r, expired_nxt;

  always_comb begin
    pre_nxt = pre_r;
    tenths_nxt = tenths_r;
    expired_nxt = expired_r;
    // A zero limit holds the timer idle and never expires
    if (tif.restart || tif.limit == '0) begin
      pre_nxt = '0;
      tenths_nxt = '0;
      expired_nxt = 1'b0;
    end else if (!expired_r) begin
      if (pre_r == PRE_LAST) begin
        pre_nxt = '0;
        if (tenths_r + 14'h0001 >= tif.limit) begin
          expired_nxt = 1'b1;
        end else begin
          tenths_nxt = tenths_r + 14'h0001;
        end
      end else begin
        pre_nxt = pre_r + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_r <= '0;
      tenths_r <= '0;
      expired_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tenths_r <= tenths_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign tif.expired = expired_r;

  chk_restart_clears: assert property (@(posedge sys_clk) disable iff (srst)
    tif.restart |=> !expired_r)
    else $error("timer still expired after restart");
endmodule
`default_nettype wire

//--- bench/cls_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module cls_master_model (
  // Clock
  input wire logic sys_clk,
  // Traffic control from the bench
  input wire logic go,
  input wire logic [4:0] dest,
  input wire logic [3:0] gap,
  input wire logic relay_go,
  // Toward the supervisor
  output logic telegram_valid,
  output logic [4:0] telegram_address,
  output logic relay_reply_valid
);
  int cnt = 0;

  initial begin
    telegram_valid = 1'b0;
    telegram_address = 5'h00;
    relay_reply_valid = 1'b0;
  end

  // Address toggles between telegrams so a stale value never looks valid
  always @(negedge sys_clk) begin
    cnt <= (cnt >= int'(gap)) ? 0 : cnt + 1;
    telegram_valid <= go && cnt == 0;
    telegram_address <= (go && cnt == 0) ? dest : ~telegram_address;
    // Relay slave at address 1..3, 2400 bps even framing at its end
    relay_reply_valid <= relay_go && cnt == 0;
  end
endmodule
`default_nettype wire

//--- bench/cls_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cls_supervisor_bench;
  import cls_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] stb = 6'h00;
  logic [13:0] wd = 14'h0000;
  logic motor_running = 1'b0;
  logic cmd_source_serial = 1'b0;
  logic comm_fault_reset = 1'b0;
  logic [2:0] pins = 3'h7;
  logic go = 1'b0;
  logic relay_go = 1'b0;
  logic [4:0] dest = 5'h01;
  logic [3:0] gap = 4'h2;
  logic telegram_valid, relay_reply_valid, rej, sen;
  logic [4:0] telegram_address, addr, alm, actv;
  logic [3:0] prof, fmt;
  logic [13:0] tmo;
  logic [2:0] act, io;
  logic [1:0] rsel, baud, par;
  cls_net_e net;
  int miscompares = 0;
  int n_tests = 0;
  int q_sel[$];
  logic [13:0] q_exp[$];
  event chk_ev;
  logic [13:0] cur[6] = '{14'h0000, 14'h0007, 14'h0000, 14'h0000,
                         14'h0000, 14'h0001};
  logic [13:0] codes[5] = '{14'h0000, 14'h0001, 14'h0002, 14'h0003,
                           14'h0005};
  int bw[7] = '{0, 1, 2, 3, 4, 5, 5};
  logic [13:0] bd[7] = '{14'h000E, 14'h000A, 14'h2707, 14'h0004,
                        14'h0003, 14'h0000, 14'h001F};
  string nm[14] = '{"profile", "format", "timeout", "action", "relay",
    "address", "reject", "net", "io", "baud_par", "alarms", "actions",
    "enable", "out_dis"};

  cls_supervisor #(.TICK_CYCLES(4)) cls_supervisor_inst (
    .sys_clk, .srst,
    .wr_profile(stb[0]), .wr_format(stb[1]), .wr_timeout(stb[2]),
    .wr_action(stb[3]), .wr_relay_sel(stb[4]), .wr_address(stb[5]),
    .wr_data_code(wd[3:0]), .wr_data_timeout(wd),
    .wr_data_address(wd[4:0]), .motor_running, .cmd_source_serial,
    .comm_fault_reset, .telegram_valid, .telegram_address,
    .relay_reply_valid, .fieldbus_link_ok(pins[2]),
    .fieldbus_card_active(pins[1]), .board_link_ok(pins[0]),
    .fieldbus_profile_select(prof), .serial_format_select(fmt),
    .serial_timeout(tmo), .comm_loss_action(act),
    .thermal_relay_link_select(rsel), .serial_station_address(addr),
    .cfg_reject(rej), .net_type(net), .io_words(io), .serial_enable(sen),
    .serial_baud_sel(baud), .serial_parity_sel(par),
    .serial_silence_alarm(alm[4]), .fieldbus_link_alarm(alm[3]),
    .fieldbus_card_alarm(alm[2]), .board_link_alarm(alm[1]),
    .relay_timeout_alarm(alm[0]), .run_stop_disable(actv[4]),
    .gen_enable_drop(actv[3]), .go_local(actv[2]), .comm_fault(actv[1]),
    .output_disable(actv[0]));

  cls_master_model cls_master_model_inst (
    .sys_clk, .go, .dest, .gap, .relay_go, .telegram_valid,
    .telegram_address, .relay_reply_valid);

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [13:0] seen(input int s);
    case (s)
      0: return {10'h000, prof};
      1: return {10'h000, fmt};
      2: return tmo;
      3: return {11'h000, act};
      4: return {12'h000, rsel};
      5: return {9'h000, addr};
      6: return {13'h0000, rej};
      7: return {11'h000, net};
      8: return {11'h000, io};
      9: return {10'h000, baud, par};
      10: return {9'h000, alm};
      11: return {10'h000, actv[4:1]};
      12: return {13'h0000, sen};
      default: return {13'h0000, actv[0]};
    endcase
  endfunction

  function automatic cls_net_e netx(input int p);
    if (p == 0) return CLS_NET_NONE;
    if (p <= 3) return CLS_NET_PROFIBUS;
    if (p <= 6) return CLS_NET_DEVICENET;
    if (p <= 9) return CLS_NET_MODBUS;
    if (p == 10) return CLS_NET_DRIVE_PROFILE;
    return CLS_NET_ETHERNET;
  endfunction

  // Bits: run/stop, general enable, local, fault
  function automatic logic [13:0] actx(input logic [13:0] c);
    case (c)
      14'h0000: return 14'h0008;
      14'h0001: return 14'h0004;
      14'h0003: return 14'h0002;
      14'h0005: return 14'h0001;
      default: return 14'h0000;
    endcase
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input int s, input logic [13:0] e);
    q_sel.push_back(s);
    q_exp.push_back(e);
    -> chk_ev;
  endtask

  // Result watcher: compares each pending note against the outputs
  always begin
    @(chk_ev);
    while (q_sel.size() > 0) begin
      n_tests++;
      if (seen(q_sel[0]) !== q_exp[0]) begin
        $display("wrong value %s expected %h seen %h", nm[q_sel[0]],
                 q_exp[0], seen(q_sel[0]));
        miscompares++;
      end
      void'(q_sel.pop_front());
      void'(q_exp.pop_front());
    end
  end

  // Strobe drops for a full cycle so writes never merge
  task automatic wr(input int w, input logic [13:0] d, input logic ok);
    stb = 6'h01 << w;
    wd = d;
    @(negedge sys_clk);
    stb = 6'h00;
    if (ok)
      cur[w] = d;
    chk(6, {13'h0000, ~ok});
    chk(w, cur[w]);
    @(negedge sys_clk);
  endtask

  task automatic wait_on(input int s, input logic [13:0] e, input int n);
    int i;
    for (i = 0; i < n && seen(s) !== e; i++)
      @(negedge sys_clk);
    if (i == n) begin
      $display("wrong value %s expected %h seen %h", nm[s], e, seen(s));
      miscompares++;
      end_of_test();
    end
  endtask

  initial begin
    void'($urandom(32'h629b_ec2e));
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 6; i++)
      chk(i, cur[i]);
    chk(12, 14'h0001);
    chk(9, 14'h0008);
    chk(10, 14'h0000);
    $display("test reset done");
    for (int f = 0; f < 10; f++) begin
      wr(1, 14'(f), 1'b1);
      chk(12, {13'h0000, f != 0});
      if (f != 0)
        chk(9, 14'(((f - 1) / 3) * 4 + (f - 1) % 3));
    end
    wr(1, 14'h0007, 1'b1);
    for (int p = 0; p < 14; p++) begin
      wr(0, 14'(p), 1'b1);
      chk(7, 14'(netx(p)));
      chk(8, (p == 0 || p == 10) ? 14'h0000 :
             14'(p > 10 ? (p - 10) * 2 : ((p - 1) % 3 + 1) * 2));
    end
    $display("test decode done");
    for (int i = 0; i < 7; i++)
      wr(bw[i], bd[i], 1'b0);
    motor_running = 1'b1;
    wr(0, 14'h0003, 1'b0);
    wr(1, 14'h0002, 1'b0);
    wr(2, 14'h0005, 1'b0);
    wr(3, codes[$urandom_range(0, 4)], 1'b1);
    wr(5, 14'($urandom_range(1, 30)), 1'b1);
    motor_running = 1'b0;
    $display("test refusals done");
    cmd_source_serial = 1'b1;
    gap = 4'($urandom_range(0, 2));
    foreach (codes[i]) begin
      wr(3, codes[i], 1'b1);
      wr(2, 14'h0001, 1'b1);
      chk(10, 14'h0000);
      wait_on(10, 14'h0010, 12);
      @(negedge sys_clk);
      chk(11, actx(codes[i]));
      dest = cur[5][4:0];
      go = 1'b1;
      wait_on(10, 14'h0000, 10);
      repeat (2) @(negedge sys_clk);
      chk(11, codes[i] == 14'h0005 ? 14'h0001 : 14'h0000);
      comm_fault_reset = 1'b1;
      @(negedge sys_clk);
      comm_fault_reset = 1'b0;
      go = 1'b0;
      wr(2, 14'h0000, 1'b1);
      chk(11, 14'h0000);
    end
    cmd_source_serial = 1'b0;
    wr(3, 14'h0000, 1'b1);
    wr(2, 14'h0001, 1'b1);
    wait_on(10, 14'h0010, 12);
    @(negedge sys_clk);
    chk(11, 14'h0000);
    wr(2, 14'h0000, 1'b1);
    repeat (20) @(negedge sys_clk);
    chk(10, 14'h0000);
    dest = cur[5] == 14'h001E ? 5'h01 : cur[5][4:0] + 5'h01;
    go = 1'b1;
    wr(2, 14'h0001, 1'b1);
    wait_on(10, 14'h0010, 12);
    dest = cur[5][4:0];
    wait_on(10, 14'h0000, 10);
    wr(2, 14'h0000, 1'b1);
    go = 1'b0;
    $display("test serial watchdog done");
    wr(3, 14'h0001, 1'b1);
    for (int k = 0; k < 3; k++) begin
      pins = ~(3'h4 >> k);
      repeat (3) @(negedge sys_clk);
      chk(10, 14'h0008 >> k);
      @(negedge sys_clk);
      chk(11, 14'h0004);
      pins = 3'h7;
      repeat (5) @(negedge sys_clk);
      chk(10, 14'h0000);
    end
    wr(0, 14'h0000, 1'b1);
    pins = 3'h3;
    repeat (5) @(negedge sys_clk);
    chk(10, 14'h0000);
    pins = 3'h7;
    $display("test pins done");
    relay_go = 1'b1;
    wr(4, 14'($urandom_range(1, 2)), 1'b1);
    repeat (60) @(negedge sys_clk);
    chk(10, 14'h0000);
    relay_go = 1'b0;
    repeat (30) @(negedge sys_clk);
    chk(10, 14'h0000);
    wait_on(10, 14'h0001, 20);
    @(negedge sys_clk);
    chk(13, 14'h0001);
    $display("test relay done");
    repeat (2) @(negedge sys_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
